// ### logic/asq_consts.svh
// Constants of the arbitrary setpoint sequencer
//
// Functional notes
// [R1] Sine periods equal frequency times point duration
// [R2] Amplitude moves linearly from start to end
// [R3] DC offset ramps start to end, sine added
// [R4] Sine starts at 0..359 degree phase
// [R5] Frequency sweeps from start to end value
// [R6] Both frequencies zero: no sine part
// [R7] Zero frequency, unequal DC: linear ramp
// [R8] Each run restarts from configured start values
// [R9] Points of a block run back to back
// [R10] Table drives voltage or current setpoint
// [R11] Whole 99-point table saved or loaded
// [R12] Accept 99 or 100 rows, 8 full columns
// [R13] Fixed column order, duration in microseconds
// [R14] Range check every value, reject on violation
// [R15] DC offset limited to nominal minus amplitude
// [R16] Separators follow configured file format
// [R17] Name prefix must match selected quantity
// [R18] Block first..last, repeated 1..999 or endless
// [R19] Point duration 0.1 ms to 36000 s
// [R20] Fixed sample rate, phase accumulator sine
`ifndef ASQ_CONSTS_SVH
`define ASQ_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ASQ_REG_CTRL   8'h00
`define ASQ_REG_BLOCK  8'h04
`define ASQ_REG_STATUS 8'h08
`define ASQ_REG_LOAD   8'h0c
`define ASQ_REG_NAME0  8'h10
`define ASQ_REG_NAME1  8'h14
`define ASQ_REG_SIDX   8'h18
`define ASQ_REG_SDATA  8'h1c
`define ASQ_REG_SHI    8'h20
`define ASQ_REG_SETPT  8'h24

// ----------------------------------------------------------------
// Control bits and reset values
// ----------------------------------------------------------------
`define ASQ_CTRL_START 0
`define ASQ_CTRL_STOP  1
`define ASQ_CTRL_CUR   2
`define ASQ_CTRL_SEPUS 3
`define ASQ_CTRL_ENDL  4
`define ASQ_CTRL_LBEG  5
`define ASQ_CTRL_LEND  6
`define ASQ_BLOCK_RST  32'h0001_6301

// ----------------------------------------------------------------
// Table limits and timing
// ----------------------------------------------------------------
`define ASQ_POINTS    7'd99
`define ASQ_ROWS_ALT  7'd100
`define ASQ_LAST_COL  4'd7
`define ASQ_FREQ_MAX  44'd1000000
`define ASQ_ANGLE_MAX 36'd359
`define ASQ_TIME_MIN  36'd100
`define ASQ_TIME_MAX  36'd36000000000
`define ASQ_INT_OVF   36'd6871947670
`define ASQ_CLK_HZ    25000000
`define ASQ_SAMPLE_NS 1000
`define ASQ_SAMPLE_CYC (`ASQ_SAMPLE_NS * (`ASQ_CLK_HZ / 1000000) / 1000)
`define ASQ_DEG_PH    32'd11930465
`define ASQ_HZ_INC    64'd2814750

`endif

// ### logic/asq_pkg.sv
// Types of the arbitrary setpoint sequencer
package asq_pkg;
  // One sequence point, values in hundredths, angle in whole degrees, duration in us
  typedef struct packed {
    logic [23:0] amp_s;
    logic [23:0] amp_e;
    logic [19:0] f_s;
    logic [19:0] f_e;
    logic [8:0]  ang;
    logic [23:0] dc_s;
    logic [23:0] dc_e;
    logic [35:0] dur;
  } asq_point_type;

  typedef enum logic [1:0] {S_IDLE, S_PREP, S_DIV, S_RUN} asq_state_type;
endpackage : asq_pkg

// ### logic/asq_div_if.sv
// Handshake between sequencer and reciprocal divider
interface asq_div_if #(parameter int W = 40);
  logic         start;
  logic [W-1:0] den;
  logic         done;
  logic [W-1:0] quo;
  modport master (output start, output den, input done, input quo);
  modport slave  (input start, input den, output done, output quo);
endinterface : asq_div_if

// ### logic/asq_div.sv
// Restoring divider computing 2^W / den, one bit per cycle
module asq_div #(
  parameter int W = 40
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  asq_div_if.slave d
);
  logic [W:0]   rem_q;
  logic [W-1:0] quo_q;
  logic [6:0]   cnt_q;
  logic         busy_q;
  logic         done_q;
  logic [W:0]   sh;

  // Shift the remainder; dividend bits after the leading one are zero
  assign sh = {rem_q[W-1:0], 1'b0};
  assign d.done = done_q;
  assign d.quo  = quo_q;

  // Iteration; den must be above one so the first quotient bit is zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rem_q  <= '0;
      quo_q  <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (d.start) begin
        rem_q  <= (W+1)'(1);
        quo_q  <= '0;
        cnt_q  <= 7'(W);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (sh >= {1'b0, d.den}) begin
          rem_q <= sh - {1'b0, d.den};
          quo_q <= {quo_q[W-2:0], 1'b1};
        end else begin
          rem_q <= sh;
          quo_q <= {quo_q[W-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 7'd1;
        if (cnt_q == 7'd1) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule : asq_div

// ### logic/asq_sequencer.sv
// Arbitrary setpoint sequencer: table loader and waveform engine
`include "asq_consts.svh"

module asq_sequencer import asq_pkg::*; #(
  parameter logic [23:0] NOM = 24'd10000
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic      [23:0] setpoint_o,
  output logic             target_current_o,
  output logic             running_o
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int SMP = `ASQ_SAMPLE_CYC;
  asq_point_type tab_q [0:98];
  asq_point_type stg_q [0:98];
  asq_point_type cur_q, rb_q, row_w;
  asq_state_type st_q;
  logic [2:0]  ctrl_q;
  logic [6:0]  first_q, last_q, idx_q, row_q;
  logic [9:0]  cycles_q, cyc_q, sidx_q;
  logic [31:0] name0_q, name1_q, rdata_q;
  logic [3:0]  col_q;
  logic [35:0] int_q, t_q;
  logic [6:0]  fr_q, frx;
  logic [1:0]  fd_q;
  logic        dig_q, infr_q, err_q, ld_q, ok_q, bad_q, nok_q;
  logic [43:0] cen;
  logic        cell_bad, cell_end, row_done, commit;
  logic        start_p, stop_p, lbeg_p, lend_p, chr_we;
  logic [7:0]  ch;
  logic        is_dig, is_col, is_dec, is_nl, is_cr;
  logic [39:0] acc_q, step_q;
  logic [31:0] ph_q, inc;
  logic [4:0]  smp_q;
  logic        tick, dstart_q, last_t;
  logic [15:0] fr16;
  logic [23:0] amp, dc, f;
  logic [35:0] sv;
  logic [23:0] setp_q;
  logic [35:0] scell;
  logic [2:0]  scol;
  logic [6:0]  srow;

  asq_div_if #(.W(40)) dif ();

  asq_div #(.W(40)) u_div (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d       (dif.slave)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Linear interpolation a + (b - a) * f / 65536
  function automatic logic [23:0] lerp(input logic [23:0] a, input logic [23:0] b,
                                       input logic [15:0] fr);
    logic signed [25:0] dv;
    logic signed [42:0] p;
    dv = $signed({2'b00, b}) - $signed({2'b00, a});
    p = dv * $signed({1'b0, fr});
    lerp = 24'($signed({19'd0, a}) + (p >>> 16));
  endfunction : lerp

  // Case-folding of ASCII letters for the name filter
  function automatic logic [7:0] up(input logic [7:0] c);
    up = (c >= 8'h61 && c <= 8'h7a) ? (c & 8'hdf) : c;
  endfunction : up

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  assign start_p = wr_i && addr_i == `ASQ_REG_CTRL && wdata_i[`ASQ_CTRL_START];
  assign stop_p  = wr_i && addr_i == `ASQ_REG_CTRL && wdata_i[`ASQ_CTRL_STOP];
  assign lbeg_p  = wr_i && addr_i == `ASQ_REG_CTRL && wdata_i[`ASQ_CTRL_LBEG];
  assign lend_p  = wr_i && addr_i == `ASQ_REG_CTRL && wdata_i[`ASQ_CTRL_LEND];
  assign chr_we  = wr_i && addr_i == `ASQ_REG_LOAD && ld_q;
  assign ch      = wdata_i[7:0];

  // Writable settings; target and separator format sit in ctrl_q
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q   <= '0;
      first_q  <= 7'(`ASQ_BLOCK_RST);
      last_q   <= 7'(`ASQ_BLOCK_RST >> 8);
      cycles_q <= 10'(`ASQ_BLOCK_RST >> 16);
      name0_q  <= '0;
      name1_q  <= '0;
    end else if (wr_i) begin
      case (addr_i)
        `ASQ_REG_CTRL:  ctrl_q <= wdata_i[`ASQ_CTRL_ENDL:`ASQ_CTRL_CUR];
        `ASQ_REG_BLOCK: begin
          first_q  <= wdata_i[6:0];
          last_q   <= wdata_i[14:8];
          cycles_q <= wdata_i[25:16];
        end
        `ASQ_REG_NAME0: name0_q <= wdata_i;
        `ASQ_REG_NAME1: name1_q <= wdata_i;
        default: ;
      endcase
    end
  end

  // Export pointer walks the whole table cell by cell
  assign srow = sidx_q[9:3];
  assign scol = sidx_q[2:0];
  always_comb begin
    case (scol)
      3'd0:    scell = 36'(tab_q[srow].amp_s);
      3'd1:    scell = 36'(tab_q[srow].amp_e);
      3'd2:    scell = 36'(tab_q[srow].f_s);
      3'd3:    scell = 36'(tab_q[srow].f_e);
      3'd4:    scell = 36'(tab_q[srow].ang);
      3'd5:    scell = 36'(tab_q[srow].dc_s);
      3'd6:    scell = 36'(tab_q[srow].dc_e);
      default: scell = tab_q[srow].dur;
    endcase
  end

  // Export index; reading the low word advances and wraps at 99 rows
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sidx_q <= '0;
    end else if (wr_i && addr_i == `ASQ_REG_SIDX) begin
      sidx_q <= wdata_i[9:0];
    end else if (rd_i && addr_i == `ASQ_REG_SDATA) begin
      sidx_q <= (sidx_q == 10'd791) ? 10'd0 : sidx_q + 10'd1; // R11
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
    end else if (rd_i) begin
      case (addr_i)
        `ASQ_REG_CTRL:   rdata_q <= {27'd0, ctrl_q, 2'b00};
        `ASQ_REG_BLOCK:  rdata_q <= {6'd0, cycles_q, 1'b0, last_q, 1'b0, first_q};
        `ASQ_REG_STATUS: rdata_q <= {6'd0, cyc_q, 1'b0, idx_q + 7'd1, 4'd0, nok_q, bad_q, ok_q, running_o};
        `ASQ_REG_NAME0:  rdata_q <= name0_q;
        `ASQ_REG_NAME1:  rdata_q <= name1_q;
        `ASQ_REG_SIDX:   rdata_q <= {22'd0, sidx_q};
        `ASQ_REG_SDATA:  rdata_q <= scell[31:0];
        `ASQ_REG_SHI:    rdata_q <= {28'd0, scell[35:32]};
        `ASQ_REG_SETPT:  rdata_q <= {8'd0, setp_q};
        default:         rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end
  assign rdata_o = rdata_q;

  // Name filter: WAVE_U or WAVE_I, any letter case
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      nok_q <= 1'b0;
    end else begin
      nok_q <= {up(name0_q[31:24]), up(name0_q[23:16]), up(name0_q[15:8]), up(name0_q[7:0])} == "WAVE"
               && name1_q[31:8] == "_"
               && up(name1_q[7:0]) == (ctrl_q[0] ? "I" : "U"); // R17
    end
  end

  // ----------------------------------------------------------------
  // Table loader
  // ----------------------------------------------------------------
  // Separator pair chosen by the file format setting
  assign is_dig = ch >= "0" && ch <= "9";
  assign is_col = ch == (ctrl_q[1] ? "," : ";"); // R16
  assign is_dec = ch == (ctrl_q[1] ? "." : ","); // R16
  assign is_nl  = ch == 8'h0a;
  assign is_cr  = ch == 8'h0d;
  assign frx    = (fd_q == 2'd1) ? 7'(fr_q * 7'd10) : fr_q;
  assign cen    = 44'(int_q) * 44'd100 + 44'(frx);
  assign cell_end = chr_we && (is_col || (is_nl && (col_q != 4'd0 || dig_q)));
  assign row_done = chr_we && is_nl && (col_q != 4'd0 || dig_q);
  assign commit = lend_p && ld_q && !err_q && col_q == 4'd0 && !dig_q
                  && (row_q == `ASQ_POINTS || row_q == `ASQ_ROWS_ALT); // R12

  // Per-cell limits, checked against the column position
  always_comb begin
    cell_bad = !dig_q; // R12
    case (col_q)
      4'd0:    cell_bad = cell_bad || cen > 44'(NOM >> 1); // R14
      4'd1:    cell_bad = cell_bad || cen > 44'(NOM >> 1); // R14
      4'd2:    cell_bad = cell_bad || cen > `ASQ_FREQ_MAX; // R14
      4'd3:    cell_bad = cell_bad || cen > `ASQ_FREQ_MAX; // R14
      4'd4:    cell_bad = cell_bad || infr_q || int_q > `ASQ_ANGLE_MAX;
      4'd5:    cell_bad = cell_bad || cen > 44'(NOM - rb_q.amp_s); // R15
      4'd6:    cell_bad = cell_bad || cen > 44'(NOM - rb_q.amp_e); // R15
      4'd7:    cell_bad = cell_bad || infr_q || int_q < `ASQ_TIME_MIN || int_q > `ASQ_TIME_MAX; // R19
      default: cell_bad = 1'b1;
    endcase
  end

  // Finished row: last cell carries the duration in microseconds
  always_comb begin
    row_w = rb_q;
    row_w.dur = int_q; // R13
  end

  // Character parser; any bad cell spoils the whole load
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || lbeg_p) begin
      col_q  <= '0;
      row_q  <= '0;
      int_q  <= '0;
      fr_q   <= '0;
      fd_q   <= '0;
      dig_q  <= 1'b0;
      infr_q <= 1'b0;
      err_q  <= 1'b0;
      rb_q   <= '0;
      ld_q   <= rst_n_i;
    end else if (lend_p) begin
      ld_q <= 1'b0;
    end else if (chr_we) begin
      if (is_dig) begin
        dig_q <= 1'b1;
        if (!infr_q) begin
          int_q <= 36'(int_q * 36'd10 + 36'(ch - "0"));
          if (int_q > `ASQ_INT_OVF) begin
            err_q <= 1'b1;
          end
        end else if (fd_q != 2'd2) begin
          fr_q <= 7'(fr_q * 7'd10 + 7'(ch - "0"));
          fd_q <= fd_q + 2'd1;
        end
      end else if (is_dec && !infr_q) begin
        infr_q <= 1'b1;
      end else if (cell_end) begin
        int_q  <= '0;
        fr_q   <= '0;
        fd_q   <= '0;
        dig_q  <= 1'b0;
        infr_q <= 1'b0;
        if (cell_bad || (is_nl && col_q != `ASQ_LAST_COL)) begin
          err_q <= 1'b1; // R12
        end
        case (col_q)
          4'd0:    rb_q.amp_s <= 24'(cen); // R13
          4'd1:    rb_q.amp_e <= 24'(cen);
          4'd2:    rb_q.f_s   <= 20'(cen);
          4'd3:    rb_q.f_e   <= 20'(cen);
          4'd4:    rb_q.ang   <= 9'(int_q);
          4'd5:    rb_q.dc_s  <= 24'(cen);
          4'd6:    rb_q.dc_e  <= 24'(cen);
          default: ;
        endcase
        if (is_nl) begin
          col_q <= '0;
          row_q <= row_q + 7'd1;
          if (row_q == `ASQ_ROWS_ALT) begin
            err_q <= 1'b1; // R12
          end
        end else begin
          col_q <= col_q + 4'd1;
        end
      end else if (!is_cr && !(is_nl && col_q == 4'd0 && !dig_q)) begin
        err_q <= 1'b1;
      end
    end
  end

  // Staging rows; the live table changes only as a whole
  always_ff @(posedge clk_i) begin
    if (row_done && row_q < `ASQ_POINTS) begin
      stg_q[row_q] <= row_w;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 99; i++) begin
        tab_q[i] <= '0;
      end
    end else if (commit) begin
      tab_q <= stg_q; // R11
    end
  end

  // Load verdict flags
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || lbeg_p) begin
      ok_q  <= 1'b0;
      bad_q <= 1'b0;
    end else if (lend_p && ld_q) begin
      ok_q  <= commit;
      bad_q <= !commit; // R14
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign tick   = st_q == S_RUN && smp_q == 5'(SMP - 1); // R20
  assign last_t = tick && t_q + 36'd1 >= cur_q.dur;
  assign dif.start = dstart_q;
  assign dif.den   = 40'(cur_q.dur);

  // Point walk; each new point reloads its own start values
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q     <= S_IDLE;
      idx_q    <= '0;
      cyc_q    <= '0;
      cur_q    <= '0;
      dstart_q <= 1'b0;
      step_q   <= '0;
    end else begin
      dstart_q <= 1'b0;
      if (stop_p) begin
        st_q <= S_IDLE;
      end else if (start_p && st_q == S_IDLE) begin
        idx_q <= first_q - 7'd1; // R18
        cyc_q <= '0;
        st_q  <= S_PREP;
      end else begin
        case (st_q)
          S_PREP: begin
            cur_q    <= tab_q[idx_q]; // R8
            dstart_q <= 1'b1;
            st_q     <= S_DIV;
          end
          S_DIV: begin
            if (dif.done) begin
              step_q <= dif.quo;
              st_q   <= S_RUN;
            end
          end
          S_RUN: begin
            if (last_t) begin
              st_q <= S_PREP; // R9
              if (idx_q + 7'd1 >= last_q) begin
                idx_q <= first_q - 7'd1;
                cyc_q <= cyc_q + 10'd1;
                if (!ctrl_q[2] && cyc_q + 10'd1 >= cycles_q) begin
                  st_q <= S_IDLE; // R18
                end
              end else begin
                idx_q <= idx_q + 7'd1; // R9
              end
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  // Sample clock, elapsed time, time fraction and phase
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      smp_q <= '0;
      t_q   <= '0;
      acc_q <= '0;
      ph_q  <= '0;
    end else if (st_q == S_PREP) begin
      smp_q <= '0;
      t_q   <= '0;
      acc_q <= '0; // R8
      ph_q  <= 32'(tab_q[idx_q].ang * `ASQ_DEG_PH); // R4
    end else if (st_q == S_RUN) begin
      smp_q <= tick ? 5'd0 : smp_q + 5'd1;
      if (tick) begin
        t_q   <= t_q + 36'd1;
        acc_q <= acc_q + step_q;
        ph_q  <= ph_q + inc; // R1
      end
    end
  end

  // Interpolated parts; fraction is not clamped and restarts at zero with each point
  assign fr16 = acc_q[39:24];
  assign amp  = lerp(cur_q.amp_s, cur_q.amp_e, fr16); // R2
  assign dc   = lerp(cur_q.dc_s, cur_q.dc_e, fr16); // R3
  assign f    = lerp(24'(cur_q.f_s), 24'(cur_q.f_e), fr16); // R5
  assign inc  = 32'((64'(f) * `ASQ_HZ_INC) >> 16); // R1

  // Parabolic half-wave sine scaled by the amplitude
  always_comb begin
    logic [11:0] x;
    logic [23:0] s;
    x  = ph_q[30:19];
    s  = 24'(({12'd0, x} * (24'd4096 - {12'd0, x})) >> 10);
    sv = (36'(amp) * 36'(s)) >> 12;
    if (cur_q.f_s == '0 && cur_q.f_e == '0) begin
      sv = '0; // R6
    end
  end

  // Setpoint sample, clamped to zero and nominal
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      setp_q <= '0;
    end else if (st_q == S_IDLE) begin
      setp_q <= '0;
    end else if (tick) begin
      if (ph_q[31]) begin
        setp_q <= (36'(dc) > sv) ? 24'(36'(dc) - sv) : 24'd0; // R4
      end else begin
        setp_q <= (36'(dc) + sv > 36'(NOM)) ? NOM : 24'(36'(dc) + sv); // R7
      end
    end
  end

  // Outputs, all registered
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      running_o        <= 1'b0;
      target_current_o <= 1'b0;
    end else begin
      running_o        <= st_q != S_IDLE;
      target_current_o <= ctrl_q[0]; // R10
    end
  end
  assign setpoint_o = setp_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_restart;
    st_q == S_PREP |=> t_q == '0 && acc_q == '0 && ph_q == 32'($past(tab_q[idx_q].ang) * `ASQ_DEG_PH);
  endproperty
  a_restart: assert property (p_restart) else $error("point did not restart from start values"); // R8

  property p_phase;
    tick |=> ph_q == $past(ph_q) + $past(inc);
  endproperty
  a_phase: assert property (p_phase) else $error("phase step differs from frequency"); // R1

  property p_nosine;
    tick && cur_q.f_s == '0 && cur_q.f_e == '0 |=> setp_q == $past(dc);
  endproperty
  a_nosine: assert property (p_nosine) else $error("sine part present at zero frequency"); // R6

  property p_next;
    last_t && idx_q + 7'd1 < last_q && !stop_p |=> st_q == S_PREP && idx_q == $past(idx_q) + 7'd1;
  endproperty
  a_next: assert property (p_next) else $error("next point not started directly"); // R9

  property p_rows;
    $rose(ok_q) |-> $past(row_q) == `ASQ_POINTS || $past(row_q) == `ASQ_ROWS_ALT;
  endproperty
  a_rows: assert property (p_rows) else $error("table accepted with wrong row count"); // R12

  property p_err;
    lend_p && ld_q && err_q |=> bad_q && !ok_q;
  endproperty
  a_err: assert property (p_err) else $error("faulty table not rejected"); // R14

  property p_target;
    ##1 target_current_o == $past(ctrl_q[0]);
  endproperty
  a_target: assert property (p_target) else $error("target select not followed"); // R10

  property p_whole;
    !$past(commit) |-> tab_q[0] == $past(tab_q[0]) && tab_q[98] == $past(tab_q[98]);
  endproperty
  a_whole: assert property (p_whole) else $error("table changed outside a commit"); // R11

  property p_time;
    $changed(t_q) && st_q == S_RUN |-> $past(tick);
  endproperty
  a_time: assert property (p_time) else $error("time advanced off the sample grid"); // R20

  property p_end;
    $fell(running_o) |-> $past(st_q) == S_IDLE;
  endproperty
  a_end: assert property (p_end) else $error("running flag out of step with state"); // R18
endmodule : asq_sequencer

// ### test/asq_power_stage.sv
// Model of the power stage that takes the generated setpoint
module asq_power_stage (
  input  wire logic        clk_i,
  input  wire logic [23:0] setpoint_i,
  input  wire logic        target_current_i,
  output logic      [23:0] volt_set_o,
  output logic      [23:0] curr_set_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Only the selected quantity follows; the other keeps its last value
  always_ff @(posedge clk_i) begin
    if (target_current_i) begin
      curr_set_o <= setpoint_i;
    end else begin
      volt_set_o <= setpoint_i;
    end
  end
endmodule : asq_power_stage

// ### test/arbitrary_setpoint_sequencer_tb_top.sv
// Self-checking bench for the arbitrary setpoint sequencer
module arbitrary_setpoint_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [23:0] setpoint_o;
  logic [23:0] volt_set;
  logic [23:0] curr_set;
  logic        target_current_o;
  logic        running_o;
  logic [31:0] cfg = 32'h0;
  logic [31:0] d;
  int          err_count = 0;
  int          comparisons = 0;

  // Clock of 40 ns
  always #20 clk_i = ~clk_i;

  asq_sequencer DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .setpoint_o(setpoint_o), .target_current_o(target_current_o),
    .running_o(running_o));
  asq_power_stage u_stage (.clk_i(clk_i), .setpoint_i(setpoint_o), .target_current_i(target_current_o),
    .volt_set_o(volt_set), .curr_set_o(curr_set));

  // ------------------------------------------------------------
  // Bus, compare and wait helpers
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask : rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // sel 0: running high, 1: running low, 2: setpoint at 10.00
  task automatic wait_for(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      if ((sel == 0 && running_o === 1'b1) || (sel == 1 && running_o === 1'b0)) return;
      if (sel == 2 && setpoint_o === 24'd1000) return;
    end
    err_count++;
    $display("CHECK FAILED at %0t: wait %0d timed out", $time, sel);
    summarize();
  endtask : wait_for

  // Sends n copies of one row, then compares the ok/rejected flags
  task automatic load(input string r, input int n, input logic [1:0] exp);
    wr(8'h00, cfg | 32'h20);
    for (int i = 0; i < n; i++) begin
      for (int j = 0; j < r.len(); j++) begin
        wr(8'h0c, {24'h0, r[j]});
      end
    end
    wr(8'h00, cfg | 32'h40);
    rd(8'h08);
    chk(32'(d[2:1]), 32'(exp));
  endtask : load

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk({6'h0, setpoint_o, target_current_o, running_o}, 32'h0);
    rd(8'h04);
    chk(d, 32'h0001_6301);
    rd(8'h30);
    chk(d, 32'h0);
  endtask : t_reset

  // Malformed and out-of-range tables first, good ones last
  task automatic t_load;
    load("0;0;0;0;0;10;10;100\n", 98, 2'b10);
    load("0;0;0;0;0;0;100\n", 99, 2'b10);
    load("0;0;10001;0;0;0;0;100\n", 99, 2'b10);
    load("30;30;0;0;0;80;80;100\n", 99, 2'b10);
    load("0;0;0;0;0;0;0;99\n", 99, 2'b10);
    cfg = 32'h8;
    load("0,0,0,0,0,10.00,10.00,100\n", 99, 2'b01);
    cfg = 32'h0;
    load("0;0;0;0;0;10,00;10,00;100\n", 100, 2'b01);
  endtask : t_load

  // Columns F, G, H of the first row, then the last cell of the table
  task automatic t_readback;
    wr(8'h18, 32'd5);
    for (int i = 0; i < 3; i++) begin
      rd(8'h20);
      chk(d, 32'h0);
      rd(8'h1c);
      chk(d, (i == 2) ? 32'd100 : 32'd1000);
    end
    wr(8'h18, 32'd791);
    rd(8'h20);
    rd(8'h1c);
    chk(d, 32'd100);
  endtask : t_readback

  task automatic t_name;
    wr(8'h10, 32'h5741_5645);
    wr(8'h14, 32'h0000_5f75);
    rd(8'h08);
    chk(32'(d[3]), 32'h1);
    cfg = 32'h4;
    wr(8'h00, cfg);
    rd(8'h08);
    chk(32'(d[3]), 32'h0);
    wr(8'h14, 32'h0000_5f49);
    rd(8'h08);
    chk(32'(d[3]), 32'h1);
  endtask : t_name

  // Two flat points of 100 us on the current setpoint, then a stop
  task automatic t_run;
    wr(8'h04, 32'h0001_0201);
    wr(8'h00, cfg | 32'h1);
    wait_for(0, 10);
    chk(32'(target_current_o), 32'h1);
    wait_for(2, 200);
    @(negedge clk_i);
    chk(32'(curr_set), 32'd1000);
    chk(32'(volt_set), 32'h0);
    repeat (1000) @(negedge clk_i);
    rd(8'h08);
    chk(32'(d[14:8]), 32'd1);
    chk(32'(setpoint_o), 32'd1000);
    repeat (2500) @(negedge clk_i);
    rd(8'h08);
    chk(32'(d[14:8]), 32'd2);
    wait_for(1, 3000);
    chk(32'(setpoint_o), 32'h0);
    rd(8'h08);
    chk(32'(d[25:16]), 32'd1);
    wr(8'h00, cfg | 32'h1);
    wait_for(0, 10);
    wr(8'h00, cfg | 32'h2);
    wait_for(1, 4);
  endtask : t_run

  // ------------------------------------------------------------
  // Verdict and main sequence
  // ------------------------------------------------------------
  task automatic summarize;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    t_reset();
    t_load();
    t_readback();
    t_name();
    t_run();
    summarize();
  end
endmodule : arbitrary_setpoint_sequencer_tb_top
